// ==== hw/psp_defines.svh ====
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// register byte offsets on the bus
`define PSP_OFS_PD_PINS 8'h00
`define PSP_OFS_PD_LATCH 8'h04
`define PSP_OFS_PD_DIR 8'h08
`define PSP_OFS_PE_PINS 8'h0C
`define PSP_OFS_PE_LATCH 8'h10
`define PSP_OFS_PE_DIR 8'h14
`define PSP_OFS_FLAGS1 8'h18
`define PSP_OFS_ENABLES1 8'h1C
`define PSP_OFS_PRIO1 8'h20
`define PSP_OFS_ANALOG_SELECT_LOW 8'h24
`define PSP_OFS_PWM_MODE 8'h28

// field positions
`define PSP_DIR_IBF_BIT 7
`define PSP_DIR_OBF_BIT 6
`define PSP_DIR_INPUT_OVERFLOW_FLAG_BIT 5
`define PSP_DIR_EN_BIT 4
`define PSP_DIR_CTL_MSB 2
`define PSP_ANALOG_SELECT_LOW_STB_MSB 7
`define PSP_ANALOG_SELECT_LOW_STB_LSB 5
`define PSP_IRQ_BIT 7
`define PSP_PWM_MULTI_BIT 0
`define PSP_PE_RD_BIT 0
`define PSP_PE_WR_BIT 1
`define PSP_PE_CS_BIT 2

// reset values
`define PSP_RST_BYTE 8'h00
`define PSP_RST_DIR_D 8'hFF
`define PSP_RST_DIR_E 3'h7
`define PSP_RST_LAT_E 3'h0
`define PSP_RST_ANALOG_SELECT_LOW 8'hFF
`define PSP_ALL_IN_D 8'hFF
`define PSP_ALL_IN_E 3'h7
`define PSP_ALL_DRIVE_D 8'h00
`define PSP_PAD_24 24'h000000
`define PSP_PAD_5 5'h00
`define PSP_RST_WORD 32'h00000000

`endif

// ==== hw/psp_pkg.sv ====
package psp_pkg;

    // one flat copy of every flip-flop in the port
    typedef struct packed {
        logic [7:0] lat_d;
        logic [7:0] dir_d;
        logic [2:0] lat_e;
        logic [2:0] dir_e;
        logic en;
        logic input_buffer_full_flag;
        logic output_buffer_full_flag;
        logic input_overflow_flag;
        logic [7:0] analog_select_low;
        logic irq_flag;
        logic irq_en;
        logic irq_prio;
        logic pwm_multi;
        logic [7:0] in_byte;
        logic [7:0] hold;
        logic wr_busy;
        logic rd_busy;
        logic wp_valid;
        logic [7:0] wp_addr;
        logic [7:0] pd_out;
        logic [7:0] pd_oe_n;
        logic [2:0] pe_out;
        logic [2:0] pe_oe_n;
        logic irq;
        logic [31:0] hrdata;
        logic hreadyout;
    } psp_state_s;

endpackage

// ==== hw/psp_top.sv ====
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "psp_defines.svh"

module psp_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // port d pins
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe_n,
    // port e pins 2..0
    input wire logic [2:0] pe_in,
    output logic [2:0] pe_out,
    output logic [2:0] pe_oe_n,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state and decode helpers

    psp_pkg::psp_state_s st_q;
    psp_pkg::psp_state_s st_d;

    // address match, shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic psp_en;
    logic strobes_ok;
    logic cs_act;
    logic wr_act;
    logic rd_act;
    logic wr_end;
    logic rd_end;
    logic accept;
    logic [7:0] ra;
    logic [7:0] wa;
    logic [7:0] wb;
    logic sw_wr_pd;
    logic sw_rd_pd;

    ////////////////////////////////////////////////////////////////////////////
    // strobe detection; pins are taken as synchronous to hclk

    // the strobe pins are only honoured in a legal configuration
    always_comb begin
        psp_en = st_q.en & ~st_q.pwm_multi;
        strobes_ok = psp_en & (&st_q.dir_e)
            & ~(|st_q.analog_select_low[`PSP_ANALOG_SELECT_LOW_STB_MSB:`PSP_ANALOG_SELECT_LOW_STB_LSB]);
        cs_act = strobes_ok & ~pe_in[`PSP_PE_CS_BIT];
        wr_act = cs_act & ~pe_in[`PSP_PE_WR_BIT];
        rd_act = cs_act & ~pe_in[`PSP_PE_RD_BIT];
        wr_end = st_q.wr_busy & ~wr_act;
        rd_end = st_q.rd_busy & ~rd_act;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // data phase of a write applies one cycle after its address phase
    always_comb begin
        accept = hsel & hready & htrans[1];
        ra = haddr[7:0];
        wa = st_q.wp_addr;
        wb = hwdata[7:0];
        sw_wr_pd = st_q.wp_valid & (hit(wa, `PSP_OFS_PD_PINS) | hit(wa, `PSP_OFS_PD_LATCH));
        sw_rd_pd = accept & ~hwrite & hit(ra, `PSP_OFS_PD_PINS);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_d = st_q;
        st_d.wp_valid = accept & hwrite;
        st_d.wp_addr = haddr[7:0];
        st_d.hreadyout = 1'b1;

        // read data is latched at the address phase so it stands in the data phase
        st_d.hrdata = `PSP_RST_WORD;
        if (accept && !hwrite) begin
            case (1'b1)
                hit(ra, `PSP_OFS_PD_PINS): st_d.hrdata[7:0] = psp_en ? st_q.in_byte : pd_in;
                hit(ra, `PSP_OFS_PD_LATCH): st_d.hrdata[7:0] = st_q.lat_d;
                hit(ra, `PSP_OFS_PD_DIR): st_d.hrdata[7:0] = st_q.dir_d;
                hit(ra, `PSP_OFS_PE_PINS): st_d.hrdata[7:0] = {`PSP_PAD_5, pe_in};
                hit(ra, `PSP_OFS_PE_LATCH): st_d.hrdata[7:0] = {`PSP_PAD_5, st_q.lat_e};
                hit(ra, `PSP_OFS_PE_DIR): begin
                    st_d.hrdata[7:0] = {st_q.input_buffer_full_flag, st_q.output_buffer_full_flag, st_q.input_overflow_flag, st_q.en, 1'b0, st_q.dir_e};
                end
                hit(ra, `PSP_OFS_FLAGS1): st_d.hrdata[`PSP_IRQ_BIT] = st_q.irq_flag;
                hit(ra, `PSP_OFS_ENABLES1): st_d.hrdata[`PSP_IRQ_BIT] = st_q.irq_en;
                hit(ra, `PSP_OFS_PRIO1): st_d.hrdata[`PSP_IRQ_BIT] = st_q.irq_prio;
                hit(ra, `PSP_OFS_ANALOG_SELECT_LOW): st_d.hrdata[7:0] = st_q.analog_select_low;
                hit(ra, `PSP_OFS_PWM_MODE): st_d.hrdata[`PSP_PWM_MULTI_BIT] = st_q.pwm_multi;
                default: st_d.hrdata = `PSP_RST_WORD; // unmapped reads zero, still OKAY
            endcase
        end

        // software register writes
        if (st_q.wp_valid) begin
            case (1'b1)
                sw_wr_pd: st_d.lat_d = wb;
                hit(wa, `PSP_OFS_PD_DIR): st_d.dir_d = wb;
                hit(wa, `PSP_OFS_PE_LATCH): st_d.lat_e = wb[`PSP_DIR_CTL_MSB:0];
                hit(wa, `PSP_OFS_PE_DIR): begin
                    st_d.en = wb[`PSP_DIR_EN_BIT];
                    st_d.dir_e = wb[`PSP_DIR_CTL_MSB:0];
                    // overflow is only cleared by writing zero; ones are ignored
                    if (!wb[`PSP_DIR_INPUT_OVERFLOW_FLAG_BIT]) begin
                        st_d.input_overflow_flag = 1'b0;
                    end
                end
                hit(wa, `PSP_OFS_FLAGS1): begin
                    if (wb[`PSP_IRQ_BIT]) begin
                        st_d.irq_flag = 1'b0;
                    end
                end
                hit(wa, `PSP_OFS_ENABLES1): st_d.irq_en = wb[`PSP_IRQ_BIT];
                hit(wa, `PSP_OFS_PRIO1): st_d.irq_prio = wb[`PSP_IRQ_BIT];
                hit(wa, `PSP_OFS_ANALOG_SELECT_LOW): st_d.analog_select_low = wb;
                hit(wa, `PSP_OFS_PWM_MODE): st_d.pwm_multi = wb[`PSP_PWM_MULTI_BIT];
                default: st_d.lat_d = st_q.lat_d;
            endcase
        end

        // software side of the buffer flags; hardware sets below win
        if (sw_rd_pd && psp_en) begin
            st_d.input_buffer_full_flag = 1'b0;
        end
        if (sw_wr_pd && psp_en && !st_q.rd_busy) begin
            st_d.output_buffer_full_flag = 1'b1;
        end

        // external write: byte is sampled every active cycle, the last one kept
        st_d.wr_busy = wr_act;
        if (wr_act) begin
            st_d.hold = pd_in;
        end
        if (wr_end) begin
            st_d.in_byte = st_q.hold;
            st_d.input_buffer_full_flag = 1'b1;
            st_d.irq_flag = 1'b1;
            if (st_q.input_buffer_full_flag) begin
                st_d.input_overflow_flag = 1'b1;
            end
        end

        // external read
        st_d.rd_busy = rd_act;
        if (rd_act && !st_q.rd_busy) begin
            st_d.output_buffer_full_flag = 1'b0;
        end
        if (rd_act && st_q.rd_busy && sw_wr_pd) begin
            st_d.output_buffer_full_flag = 1'b0;
        end
        if (rd_end) begin
            st_d.irq_flag = 1'b1;
        end

        // pins follow next state so new latch data is driven at once
        st_d.pd_out = st_d.lat_d;
        if (st_d.rd_busy) begin
            st_d.pd_oe_n = `PSP_ALL_DRIVE_D;
        end else if (psp_en) begin
            st_d.pd_oe_n = `PSP_ALL_IN_D;
        end else begin
            st_d.pd_oe_n = st_d.dir_d;
        end
        st_d.pe_out = st_d.lat_e;
        st_d.pe_oe_n = st_d.dir_e;
        st_d.irq = st_d.irq_flag & st_d.irq_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // every field reset to a constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q.lat_d <= `PSP_RST_BYTE;
            st_q.dir_d <= `PSP_RST_DIR_D;
            st_q.lat_e <= `PSP_RST_LAT_E;
            st_q.dir_e <= `PSP_RST_DIR_E;
            st_q.en <= 1'b0;
            st_q.input_buffer_full_flag <= 1'b0;
            st_q.output_buffer_full_flag <= 1'b0;
            st_q.input_overflow_flag <= 1'b0;
            st_q.analog_select_low <= `PSP_RST_ANALOG_SELECT_LOW;
            st_q.irq_flag <= 1'b0;
            st_q.irq_en <= 1'b0;
            st_q.irq_prio <= 1'b1;
            st_q.pwm_multi <= 1'b0;
            st_q.in_byte <= `PSP_RST_BYTE;
            st_q.hold <= `PSP_RST_BYTE;
            st_q.wr_busy <= 1'b0;
            st_q.rd_busy <= 1'b0;
            st_q.wp_valid <= 1'b0;
            st_q.wp_addr <= `PSP_RST_BYTE;
            st_q.pd_out <= `PSP_RST_BYTE;
            st_q.pd_oe_n <= `PSP_ALL_IN_D;
            st_q.pe_out <= `PSP_RST_LAT_E;
            st_q.pe_oe_n <= `PSP_ALL_IN_E;
            st_q.irq <= 1'b0;
            st_q.hrdata <= `PSP_RST_WORD;
            st_q.hreadyout <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops except hresp, tied to zero

    assign hreadyout = st_q.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_q.hrdata;
    assign pd_out = st_q.pd_out;
    assign pd_oe_n = st_q.pd_oe_n;
    assign pe_out = st_q.pe_out;
    assign pe_oe_n = st_q.pe_oe_n;
    assign irq = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // blocked by multi-output pwm, no access may start
    AST_PWM_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.pwm_multi |=> !st_q.rd_busy && !st_q.wr_busy)
        else $error("slave port active during multi-output pwm");

    AST_WR_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_act && st_q.wr_busy) |=> st_q.wr_busy && st_q.hold == $past(pd_in))
        else $error("write ended while strobes held low");

    AST_WR_END: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_end |=> st_q.input_buffer_full_flag && st_q.irq_flag && st_q.in_byte == $past(st_q.hold))
        else $error("write end did not capture byte and set flags");

    AST_RD_START: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_act && !st_q.rd_busy) |=> !st_q.output_buffer_full_flag && st_q.pd_oe_n == `PSP_ALL_DRIVE_D
            && st_q.pd_out == st_q.lat_d)
        else $error("read start did not drive latch or clear output-full");

    AST_RD_NEWDATA: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_act && st_q.rd_busy && sw_wr_pd) |=> !st_q.output_buffer_full_flag && st_q.pd_out == $past(wb))
        else $error("write during read mishandled");

    AST_RD_END: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_end && !rd_act) |=> st_q.irq_flag && st_q.pd_oe_n != `PSP_ALL_DRIVE_D
            || st_q.irq_flag && !psp_en)
        else $error("read end did not release pins and flag");

    AST_CFG_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        !strobes_ok |=> !st_q.rd_busy && !st_q.wr_busy)
        else $error("strobes honoured in illegal configuration");

    AST_SW_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (sw_rd_pd && psp_en && !wr_end) |=> !st_q.input_buffer_full_flag)
        else $error("software read did not clear input-full");

    AST_OVERFLOW: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_end && st_q.input_buffer_full_flag) |=> st_q.input_overflow_flag ##1 st_q.input_overflow_flag || $past(st_q.wp_valid))
        else $error("overflow not raised or not sticky");

endmodule

// ==== tb/psp_ext_cpu.sv ====
`timescale 1ns/1ps

// external byte-wide processor that strobes the slave port
module psp_ext_cpu (
    // clock
    input wire logic hclk,
    // device port d pins
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe_n,
    output logic [7:0] pd_in,
    // strobes: bit0 read, bit1 write, bit2 select, all active low
    output logic [2:0] pe_in
);
    logic [7:0] bus_q = 8'h00;
    logic drv_q = 1'b0;
    logic [7:0] last_q = 8'h00;

    initial pe_in = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // wire level: device, then master, else a floating bus that flips every cycle
    always_comb begin
        pd_in = (~pd_oe_n & pd_out) | (pd_oe_n & (drv_q ? bus_q : ~last_q));
    end

    // history for the floating-bus pattern
    always @(posedge hclk) begin
        last_q <= pd_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write: select and write strobe held low for n edges, data held one edge past
    task automatic ext_write(input logic [7:0] b, input int n);
        pe_in <= 3'h1;
        drv_q <= 1'b1;
        bus_q <= b;
        repeat (n) @(posedge hclk);
        pe_in <= 3'h7;
        @(posedge hclk);
        drv_q <= 1'b0;
        // one idle edge so a following call never re-drives drv_q in this step
        @(posedge hclk);
    endtask

    // read: select and read strobe low, byte taken at the last edge before release
    task automatic ext_read(output logic [7:0] b, input int n);
        pe_in <= 3'h2;
        repeat (n) @(posedge hclk);
        b = pd_in;
        pe_in <= 3'h7;
    endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps

module testbench;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] pd_in;
    logic [7:0] pd_out;
    logic [7:0] pd_oe_n;
    logic [2:0] pe_in;
    logic [2:0] pe_out;
    logic [2:0] pe_oe_n;
    logic irq;
    logic [7:0] b;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] bad_a [3] = '{8'h28, 8'h24, 8'h14};
    logic [7:0] bad_v [3] = '{8'h01, 8'h20, 8'h13};
    logic [7:0] good_v [3] = '{8'h00, 8'h00, 8'h17};

    psp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pe_in(pe_in),
        .pe_out(pe_out), .pe_oe_n(pe_oe_n), .irq(irq));

    psp_ext_cpu m_u (.hclk(hclk), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_in(pd_in),
        .pe_in(pe_in));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and a hang limit well above the expected run of about 120 cycles
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare, verdict, and bus cycles
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hold each phase until hready is seen high at an edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 8'h00, r);
        chk($sformatf("reg %h", a), r, {24'h000000, exp});
        chk("hresp", hresp, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(8'h14, 8'h07);
        rdc(8'h24, 8'hFF);
        rdc(8'h20, 8'h80);
        rdc(8'h2C, 8'h00);
        $display("test reset values done");
        // enable slave mode, load the latch for the far side
        wr(8'h24, 8'h00);
        wr(8'h14, 8'h17);
        wr(8'h1C, 8'h80);
        wr(8'h00, 8'h5A);
        rdc(8'h14, 8'h57);
        m_u.ext_read(b, 4);
        chk("ext read", b, 8'h5A);
        rdc(8'h14, 8'h17);
        chk("oe after read", pd_oe_n, 8'hFF);
        rdc(8'h18, 8'h80);
        chk("irq set", irq, 1'b1);
        wr(8'h18, 8'h80);
        // the clear lands at the edge that ends the data phase; look one edge later
        @(posedge hclk);
        chk("irq clear", irq, 1'b0);
        chk("pe dir", pe_oe_n, 3'h7);
        $display("test external read done");
        // one write, then two without draining
        m_u.ext_write(8'hC3, 1);
        rdc(8'h14, 8'h97);
        rdc(8'h18, 8'h80);
        rdc(8'h00, 8'hC3);
        rdc(8'h14, 8'h17);
        m_u.ext_write(8'h3C, 3);
        m_u.ext_write(8'h66, 2);
        rdc(8'h14, 8'hB7);
        wr(8'h14, 8'h17);
        rdc(8'h14, 8'h97);
        wr(8'h18, 8'h80);
        rdc(8'h00, 8'h66);
        $display("test external write done");
        // software write while the far side is mid-read
        fork
            m_u.ext_read(b, 12);
            begin
                repeat (4) @(posedge hclk);
                chk("oe in read", pd_oe_n, 8'h00);
                wr(8'h00, 8'hA5);
            end
        join
        chk("late data", b, 8'hA5);
        rdc(8'h14, 8'h17);
        $display("test write during read done");
        // the read above ended and raised the flag; clear it before the blocked cases
        wr(8'h18, 8'h80);
        // each illegal setup blocks the strobes
        for (int i = 0; i < 3; i++) begin
            wr(bad_a[i], bad_v[i]);
            m_u.ext_write(8'h81, 2);
            rdc(8'h14, bad_v[i] == 8'h13 ? 8'h13 : 8'h17);
            rdc(8'h18, 8'h00);
            wr(bad_a[i], good_v[i]);
        end
        $display("test illegal setups done");
        results();
    end
endmodule
